// >>> hdl/lprb_top.sv
// lprb_top: read position command interpreter of a LIN slave node
// assumes a LIN frame layer on core_clk delivers header ids and data bytes
// and pulls response bytes with txTake; parity is checked by that layer
// Behaviour
// - return position plus quick status byte
// - reading leaves all status flags untouched
// - accept direct frame or prepare plus read
// - direct id has bit5 one, bit4 zero
// - direct answer: switch/address, position, status
// - short prepare: id bit5 zero, cmd, addr
// - indirect answer: address, position, status, fill
// - indirect read valid only right after prepare
// - indirect read uses reserved id 3D
`timescale 1ns/1ns
module lprb_top
  import lprb_pkg::*;
#(
  parameter logic [3:0] DIRECT_ID = LPRB_DYN_ID_RST,
  parameter logic [4:0] PREP_ID = LPRB_PREP_ID_RST
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic headerValid,
  input wire logic [7:0] headerId,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic frameEnd,
  input wire logic txTake,
  input wire logic [6:0] nodeAddr,
  input wire logic [15:0] actualPosition,
  input wire logic externalSwitchState,
  input wire logic digitalSupplyResetFlag,
  input wire logic stepLossFlag,
  input wire logic electricalDefectFlag,
  input wire logic undervoltageFlag,
  input wire logic thermalShutdownFlag,
  input wire logic thermalWarningFlag,
  input wire logic [1:0] temperatureInfo,
  output logic txActive,
  output logic [7:0] txByte,
  output logic prepArmed
);
  // complete state of the interpreter
  typedef struct packed {
    lprb_state_e state;
    lprb_frame_e frame;
    logic [3:0] count;
    logic armed;
    logic direct;
    logic [15:0] pos;
    logic [7:0] status;
    logic sw;
    logic swMeta;
    logic swSync;
    logic good;
  } lprb_s;

  lprb_s st_reg;
  lprb_s st_next;
  logic [7:0] respByte;

  function automatic logic idMatch(input logic [7:0] id, input logic [5:0] v);
    idMatch = (id[5:0] == v);
  endfunction : idMatch

  // own address byte: flag bit set, programmed address below
  function automatic logic addrByteOk(input logic [7:0] b,
                                      input logic [6:0] a);
    addrByteOk = (b == {1'b1, a});
  endfunction : addrByteOk

  // command byte asking for the position readback
  function automatic logic readCmdOk(input logic [7:0] b);
    readCmdOk = (b == {1'b1, LPRB_CMD_READ_POS});
  endfunction : readCmdOk

  // direct reading id: bit5 set, bit4 clear, own dynamic id
  function automatic logic directIdOk(input logic [7:0] id);
    directIdOk = id[LPRB_ID_BIT5] && !id[LPRB_ID_BIT4]
      && (id[3:0] == DIRECT_ID);
  endfunction : directIdOk

  // short prepare id: bit5 clear, own dynamic id
  function automatic logic prepIdOk(input logic [7:0] id);
    prepIdOk = !id[LPRB_ID_BIT5] && (id[4:0] == PREP_ID);
  endfunction : prepIdOk

  // bytes a prepare frame needs before it may arm
  function automatic logic [3:0] prepLen(input lprb_frame_e f);
    prepLen = (f == LPRB_F_LONG) ? 4'(LPRB_LONG_PREP_LEN)
                                 : 4'(LPRB_SHORT_PREP_LEN);
  endfunction : prepLen

  // index of the last answer byte of a reading frame
  function automatic logic [3:0] lastIdx(input logic direct);
    lastIdx = direct ? 4'(LPRB_DIRECT_LEN - 1)
                     : 4'(LPRB_INDIRECT_LEN - 1);
  endfunction : lastIdx

  // byte counter that holds at its top instead of wrapping
  function automatic logic [3:0] bump(input logic [3:0] c);
    bump = (c == 4'hF) ? c : c + 4'h1;
  endfunction : bump

  lprb_resp_sel u_sel (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .direct(st_next.direct),
    .index(st_next.count[2:0]),
    .switchState(st_next.sw),
    .nodeAddr(nodeAddr),
    .actualPosition(st_next.pos),
    .quickStatus(st_next.status),
    .respByte(respByte)
  );

  always_comb begin
    st_next = st_reg;
    // two stage synchroniser for the switch pin
    st_next.swMeta = externalSwitchState;
    st_next.swSync = st_reg.swMeta;
    // frame decode, one frame at a time
    case (st_reg.state)
      LPRB_IDLE: begin
        if (headerValid) begin
          st_next.count = 4'h0;
          st_next.good = 1'b1;
          // snapshot only; flags are read, never cleared
          st_next.pos = actualPosition;
          st_next.status = {digitalSupplyResetFlag, stepLossFlag,
            electricalDefectFlag, undervoltageFlag, thermalShutdownFlag,
            thermalWarningFlag, temperatureInfo};
          // only the second synchroniser stage feeds the answer
          st_next.sw = st_reg.swSync;
          if (directIdOk(headerId)) begin
            st_next.frame = LPRB_F_NONE;
            st_next.direct = 1'b1;
            st_next.armed = 1'b0;
            st_next.state = LPRB_TX_DATA;
          end else if (idMatch(headerId, LPRB_ID_INDIRECT)) begin
            st_next.direct = 1'b0;
            st_next.frame = LPRB_F_INDIRECT;
            st_next.armed = 1'b0;
            // read frame only valid right after prepare
            st_next.state = st_reg.armed ? LPRB_TX_DATA : LPRB_SKIP;
          end else if (idMatch(headerId, LPRB_ID_PREP_LONG[5:0])) begin
            st_next.frame = LPRB_F_LONG;
            st_next.armed = 1'b0;
            st_next.state = LPRB_RX_DATA;
          end else if (prepIdOk(headerId)) begin
            st_next.frame = LPRB_F_SHORT;
            st_next.armed = 1'b0;
            st_next.state = LPRB_RX_DATA;
          end else begin
            st_next.armed = 1'b0;
            st_next.state = LPRB_SKIP;
          end
        end
      end
      LPRB_RX_DATA: begin
        // bytes of a prepare frame
        if (rxValid) begin
          st_next.count = bump(st_reg.count);
          if (st_reg.frame == LPRB_F_LONG) begin
            case (st_reg.count)
              4'h0: if (rxByte != LPRB_APP_CMD) st_next.good = 1'b0;
              4'h1: if (!readCmdOk(rxByte)) st_next.good = 1'b0;
              4'h2: if (!addrByteOk(rxByte, nodeAddr))
                st_next.good = 1'b0;
              default: ;
            endcase
          end else begin
            case (st_reg.count)
              4'h0: if (!readCmdOk(rxByte)) st_next.good = 1'b0;
              4'h1: if (!addrByteOk(rxByte, nodeAddr))
                st_next.good = 1'b0;
              default: ;
            endcase
          end
        end
        if (frameEnd) begin
          // arm only on a complete, well formed prepare
          st_next.armed = st_reg.good
            && (st_reg.count >= prepLen(st_reg.frame));
          st_next.state = LPRB_IDLE;
        end
      end
      LPRB_TX_DATA: begin
        if (txTake) begin
          st_next.count = bump(st_reg.count);
          // the answer stops after its last byte
          if (st_reg.count == lastIdx(st_reg.direct))
            st_next.state = LPRB_SKIP;
        end
        if (frameEnd) st_next.state = LPRB_IDLE;
      end
      LPRB_SKIP: begin
        // frames not meant for this node run out here
        if (frameEnd) st_next.state = LPRB_IDLE;
      end
      default: st_next.state = LPRB_IDLE;
    endcase
  end

  // all state in one register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: LPRB_IDLE, frame: LPRB_F_NONE, count: 4'h0,
        armed: 1'b0, direct: 1'b0, pos: 16'h0000, status: 8'h00,
        sw: 1'b0, swMeta: 1'b0, swSync: 1'b0, good: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // answering while in the transmit state
  assign txActive = (st_reg.state == LPRB_TX_DATA);
  assign txByte = respByte;
  assign prepArmed = st_reg.armed;
endmodule : lprb_top

// >>> include/lprb_pkg.sv
// lprb_pkg: constants for the position readback command interpreter
// assumes a byte-level LIN frame layer on the same clock feeds the block
package lprb_pkg;
  localparam logic [7:0] LPRB_ID_PREP_LONG = 8'h3C;
  localparam logic [5:0] LPRB_ID_INDIRECT = 6'h3D;
  localparam logic [7:0] LPRB_APP_CMD = 8'h80;
  localparam logic [6:0] LPRB_CMD_READ_POS = 7'h00;
  localparam logic [7:0] LPRB_FILL = 8'hFF;
  localparam int LPRB_DIRECT_LEN = 4;
  localparam int LPRB_INDIRECT_LEN = 8;
  localparam int LPRB_LONG_PREP_LEN = 8;
  localparam int LPRB_SHORT_PREP_LEN = 2;
  localparam int LPRB_ID_BIT5 = 5;
  localparam int LPRB_ID_BIT4 = 4;
  localparam int LPRB_FLAG_BIT = 7;
  localparam logic [3:0] LPRB_DYN_ID_RST = 4'h0;
  localparam logic [4:0] LPRB_PREP_ID_RST = 5'h00;
  typedef enum logic [2:0] {
    LPRB_IDLE, LPRB_RX_DATA, LPRB_TX_DATA, LPRB_SKIP
  } lprb_state_e;
  typedef enum logic [1:0] {
    LPRB_F_NONE, LPRB_F_SHORT, LPRB_F_LONG, LPRB_F_INDIRECT
  } lprb_frame_e;
endpackage : lprb_pkg

// >>> hdl/lprb_resp_sel.sv
// lprb_resp_sel: picks the response byte for a given frame position
// assumes inputs are next-state values from lprb_top on core_clk
`timescale 1ns/1ns
module lprb_resp_sel
  import lprb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic direct,
  input wire logic [2:0] index,
  input wire logic switchState,
  input wire logic [6:0] nodeAddr,
  input wire logic [15:0] actualPosition,
  input wire logic [7:0] quickStatus,
  output logic [7:0] respByte
);
  logic [7:0] sel;
  always_comb begin
    sel = LPRB_FILL;
    if (direct) begin
      case (index)
        3'h0: sel = {switchState, nodeAddr};
        3'h1: sel = actualPosition[15:8];
        3'h2: sel = actualPosition[7:0];
        3'h3: sel = quickStatus;
        default: sel = LPRB_FILL;
      endcase
    end else begin
      case (index)
        3'h0: sel = {1'b1, nodeAddr};
        3'h1: sel = actualPosition[15:8];
        3'h2: sel = actualPosition[7:0];
        3'h3: sel = quickStatus;
        default: sel = LPRB_FILL;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      respByte <= 8'h00;
    end else begin
      respByte <= sel;
    end
  end
endmodule : lprb_resp_sel

// >>> tb/lprb_top_assertions.sv
// lprb_top_assertions: port timing checks on lprb_top
// assumes bind into lprb_top, one clock core_clk
`timescale 1ns/1ns
module lprb_top_assertions
  import lprb_pkg::*;
#(
  parameter logic [3:0] DIRECT_ID = 4'h0,
  parameter logic [4:0] PREP_ID = 5'h00
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic headerValid,
  input wire logic [7:0] headerId,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic frameEnd,
  input wire logic txTake,
  input wire logic [6:0] nodeAddr,
  input wire logic [15:0] actualPosition,
  input wire logic externalSwitchState,
  input wire logic txActive,
  input wire logic [7:0] txByte,
  input wire logic prepArmed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hdr(logic [5:0] id);
    headerValid && headerId[5:0] == id;
  endsequence
  sequence s_prep;
    s_hdr({1'b0, PREP_ID}) ##1 rxValid && rxByte == 8'h80
      ##1 rxValid && rxByte[7] ##1 frameEnd;
  endsequence
  property p_dir;
    s_hdr({2'b10, DIRECT_ID}) |=> txActive
      && txByte == {$past(externalSwitchState, 3), $past(nodeAddr)};
  endproperty
  a_dir: assert property (p_dir) else $error("first byte");
  property p_hi;
    s_hdr({2'b10, DIRECT_ID}) ##1 txTake
      |=> txByte == $past(actualPosition, 2) >> 8;
  endproperty
  a_hi: assert property (p_hi) else $error("position high");
  property p_un;
    s_hdr(LPRB_ID_INDIRECT) ##0 !prepArmed |=> !txActive;
  endproperty
  a_un: assert property (p_un) else $error("unarmed answer");
  property p_arm;
    s_hdr(LPRB_ID_INDIRECT) ##0 prepArmed
      |=> txActive && txByte == {1'b1, $past(nodeAddr)};
  endproperty
  a_arm: assert property (p_arm) else $error("armed answer");
  property p_sil;
    s_hdr({1'b0, PREP_ID}) |=> !txActive;
  endproperty
  a_sil: assert property (p_sil) else $error("prepare answered");
  property p_prep;
    s_prep |=> prepArmed == ($past(rxByte, 2) == {1'b1, $past(nodeAddr)});
  endproperty
  a_prep: assert property (p_prep) else $error("arming");
  property p_dis;
    s_hdr({2'b10, DIRECT_ID}) |-> ##[1:4] !prepArmed;
  endproperty
  a_dis: assert property (p_dis) else $error("not disarmed");
  property p_std;
    txActive && !txTake && !frameEnd |=> $stable(txByte);
  endproperty
  a_std: assert property (p_std) else $error("byte moved");
endmodule : lprb_top_assertions

// >>> tb/lprb_lin_master.sv
// lprb_lin_master: frame level model of the bus master
// assumes one frame at a time, driven at rising edges
`timescale 1ns/1ns
module lprb_lin_master (
  input wire logic core_clk,
  output logic headerValid,
  output logic [7:0] headerId,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic frameEnd,
  output logic txTake
);
  initial {headerValid, headerId, rxValid, rxByte, frameEnd, txTake} = 20'h0;
  task automatic frame(input logic [7:0] id, input logic [63:0] d,
                       input int nrx, input int ntk);
    @(posedge core_clk);
    headerValid <= 1'b1;
    headerId <= id;
    for (int k = 0; k < nrx + ntk; k++) begin
      @(posedge core_clk);
      headerValid <= 1'b0;
      headerId <= ~id;
      rxValid <= k < nrx;
      rxByte <= d[63 - 8 * k -: 8];
      txTake <= k >= nrx;
    end
    @(posedge core_clk);
    {headerValid, rxValid, txTake} <= 3'h0;
    rxByte <= ~rxByte;
    frameEnd <= 1'b1;
    @(posedge core_clk);
    frameEnd <= 1'b0;
  endtask : frame
endmodule : lprb_lin_master

// >>> tb/lprb_top_tb.sv
// lprb_top_tb: self-checking bench for lprb_top
// assumes lprb_lin_master as frame layer and the bound checker
`timescale 1ns/1ns
module lprb_top_tb;
  import lprb_pkg::*;
  logic core_clk = 0, rst_n = 0, externalSwitchState, txActive, prepArmed;
  logic headerValid, rxValid, frameEnd, txTake;
  logic [7:0] headerId, rxByte, txByte, st, e;
  logic [6:0] nodeAddr;
  logic [15:0] actualPosition;
  logic [7:0] expQ[$];
  int num_errors = 0, num_checks = 0, seed = 65293;
  lprb_top #(.DIRECT_ID(4'h5), .PREP_ID(5'h0A)) u_dut (.*,
    .digitalSupplyResetFlag(st[7]), .stepLossFlag(st[6]),
    .electricalDefectFlag(st[5]), .undervoltageFlag(st[4]),
    .thermalShutdownFlag(st[3]), .thermalWarningFlag(st[2]),
    .temperatureInfo(st[1:0]));
  lprb_lin_master u_mst (.*);
  initial forever #10 core_clk = ~core_clk;
  task chk_byte(input logic [7:0] x, input logic [7:0] got);
    num_checks++;
    if (got !== x) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, x);
    end
  endtask : chk_byte
  task chk_flag(input logic x, input logic got);
    num_checks++;
    if (got !== x) begin
      num_errors++;
      $display("wrong value at %0t: armed %b not %b", $time, got, x);
    end
  endtask : chk_flag
  task push(input logic [63:0] d, input int n);
    for (int k = 0; k < n; k++) expQ.push_back(d[63 - 8 * k -: 8]);
  endtask : push
  task rddir;
    push({externalSwitchState, nodeAddr, actualPosition, st, 32'h0}, 4);
    u_mst.frame(8'h65, 64'h0, 0, 4);
  endtask : rddir
  task rd3d(input logic x);
    if (x) push({1'b1, nodeAddr, actualPosition, st, 32'hFFFFFFFF}, 8);
    u_mst.frame(8'h7D, 64'h0, 0, 8);
  endtask : rd3d
  task prep(input logic [6:0] a, input logic lng);
    if (lng) u_mst.frame(8'h3C, {16'h8080, 1'b1, a, 40'hFFFFFFFFFF}, 8, 0);
    else u_mst.frame(8'h0A, {8'h80, 1'b1, a, 48'h0}, 2, 0);
    #1 chk_flag(a == nodeAddr, prepArmed);
  endtask : prep
  always @(posedge core_clk) if (txActive === 1'b1 && txTake === 1'b1) begin
    e = expQ.size() > 0 ? expQ.pop_front() : 8'bx;
    chk_byte(e, txByte);
  end
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    {nodeAddr, externalSwitchState, st, actualPosition} = 32'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {nodeAddr, externalSwitchState, st, actualPosition} <= $random(seed);
      @(posedge core_clk);
      rddir();
      prep(nodeAddr, i[0]);
      rd3d(1'b1);
    end
    rd3d(1'b0);
    prep(nodeAddr, 1'b0);
    rddir();
    rd3d(1'b0);
    prep(nodeAddr + 7'h01, 1'b1);
    rd3d(1'b0);
    chk_byte(8'h00, 8'(expQ.size()));
    end_sim();
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : lprb_top_tb
bind lprb_top lprb_top_assertions #(.DIRECT_ID(DIRECT_ID),
  .PREP_ID(PREP_ID)) u_chk (.*);
